// ---- rtl/tppg_top.sv ----
// Test-pattern generator: random sequence and zero-substitution engines
// with an AXI4-Lite register slave.
// Assumes one bit per aclk cycle; the pattern pin faces the unit under test.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module tppg_top
  import tppg_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Pattern output
  output logic                   pattern_out,
  output logic                   loading
);

  // Configuration
  logic [2:0]       source;
  logic [7:0]       prbs_cfg;
  logic [5:0]       zs_cfg;
  logic [CNT_W-1:0] zs_count;

  // Write channel state
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [3:0]        w_strb;
  logic              wr_fire;
  logic              wr_hit;

  // Read channel
  logic [DATA_W-1:0] rd_word;
  logic              rd_hit;

  // Engine
  logic [2:0]        stage_sel;
  logic              lfsr_load;
  logic              lfsr_step;
  logic              seq_bit;
  logic [6:0]        hist;
  logic [CNT_W-1:0]  pos;
  logic [CNT_W-1:0]  period_m1;
  logic [CNT_W-1:0]  zeros_eff;
  logic [CNT_W-1:0]  zeros_max;
  logic [CNT_W-1:0]  base_len;
  logic [7:0]        load_cnt;
  logic              zs_start;
  logic              logic_bit;
  logic              neg;
  logic              next_pattern;

  // Merge byte lanes of a write into an old register value
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [3:0]        strb
  );
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_SOURCE) || (a == OFS_PRBS) || (a == OFS_ZSUB) ||
           (a == OFS_ZCOUNT) || (a == OFS_STATUS);
  endfunction : addr_mapped

  // Write address and data are taken independently, one write at a time
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit  = addr_mapped(aw_addr) && (aw_addr != OFS_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held       <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_held       <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register stores; a source code outside the six is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source   <= RST_SOURCE;
      prbs_cfg <= RST_PRBS;
      zs_cfg   <= RST_ZSUB;
      zs_count <= RST_ZCOUNT;
    end else if (wr_fire) begin
      case (aw_addr)
        OFS_SOURCE: begin
          if (merge(32'(source), w_data, w_strb) <= 32'(SRC_SEQ)) begin
            source <= 3'(merge(32'(source), w_data, w_strb));
          end
        end
        OFS_PRBS:   prbs_cfg <= 8'(merge(32'(prbs_cfg), w_data, w_strb));
        OFS_ZSUB: begin
          // Stage index seven is stored as written and clamped where it
          // is used, so software reads back exactly what it wrote
          zs_cfg <= 6'(merge(32'(zs_cfg), w_data, w_strb));
        end
        OFS_ZCOUNT: zs_count <= CNT_W'(merge(32'(zs_count), w_data,
                                             w_strb));
        default: begin
        end
      endcase
    end
  end

  // Read: one read at a time, data one cycle after the address
  assign rd_hit = addr_mapped(s_axi_araddr);

  always_comb begin
    case (s_axi_araddr)
      OFS_SOURCE: rd_word = 32'(source);
      OFS_PRBS:   rd_word = 32'(prbs_cfg);
      OFS_ZSUB:   rd_word = 32'(zs_cfg);
      OFS_ZCOUNT: rd_word = 32'(zs_count);
      OFS_STATUS: rd_word = {29'h0, pattern_out, load_cnt != 8'h0,
                             loading};
      default:    rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      s_axi_rvalid  <= !s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Pattern engine
  // A zero-substitution stage index of seven would be a 31-stage base,
  // which that mode does not offer; it is held at the 23-stage ceiling.
  always_comb begin
    if (source == 3'(SRC_ZSUB)) begin
      stage_sel = (zs_cfg[ZS_STAGE_LSB +: 3] > 3'(ZS_MAX_STAGE)) ?
                  3'(ZS_MAX_STAGE) : zs_cfg[ZS_STAGE_LSB +: 3];
    end else begin
      stage_sel = prbs_cfg[PRBS_STAGE_LSB +: 3];
    end
  end

  // Loading starts on entry into zero-substitution or on any change of it
  assign zs_start = wr_fire && (source == 3'(SRC_ZSUB) || (aw_addr ==
                    OFS_SOURCE && w_data[2:0] == 3'(SRC_ZSUB) &&
                    w_strb[0])) && (aw_addr == OFS_SOURCE ||
                    aw_addr == OFS_ZSUB || aw_addr == OFS_ZCOUNT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_cnt <= '0;
    end else if (zs_start) begin
      load_cnt <= 8'(LOAD_CYCLES);
    end else if (load_cnt != 8'h0) begin
      load_cnt <= load_cnt - 8'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loading <= 1'b0;
    end else begin
      loading <= zs_start || load_cnt > 8'h1;
    end
  end

  // Any configuration write except to the zero count restarts the register from its seed, as does every loading cycle
  assign lfsr_load = wr_fire && wr_hit && aw_addr != OFS_ZCOUNT ||
                     load_cnt != 8'h0;

  // Zero-substitution frame: the base period, plus one bit at 2^n
  assign base_len  = CNT_W'((32'h1 << stage_n(stage_sel)) - 32'h1);
  assign period_m1 = zs_cfg[ZS_POW2_BIT] ? base_len : base_len - 1'b1;
  assign zeros_max = zs_cfg[ZS_POW2_BIT] ? base_len : base_len - 1'b1;
  always_comb begin
    if (zs_count == '0) begin
      zeros_eff = CNT_W'(1);
    end else if (zs_count > zeros_max) begin
      zeros_eff = zeros_max;
    end else begin
      zeros_eff = zs_count;
    end
  end

  // The extra 2^n-th bit holds the register so the period stays aligned
  assign lfsr_step = (source == 3'(SRC_PRBS)) ||
                     (source == 3'(SRC_ZSUB) && pos != base_len);

  always_ff @(posedge aclk) begin
    if (!aresetn || lfsr_load || source != 3'(SRC_ZSUB)) begin
      pos <= '0;
    end else if (pos >= period_m1) begin
      pos <= '0;
    end else begin
      pos <= pos + 1'b1;
    end
  end

  tppg_lfsr u_lfsr (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .stage_idx (stage_sel),
    .load      (lfsr_load),
    .step      (lfsr_step),
    .seq_bit   (seq_bit)
  );

  // History of past sequence bits for the shifted copies
  always_ff @(posedge aclk) begin
    if (!aresetn || lfsr_load) begin
      hist <= '0;
    end else if (lfsr_step) begin
      hist <= {hist[5:0], seq_bit};
    end
  end

  // Logical bit before polarity
  always_comb begin
    logic d1;
    logic d2;
    d1 = 1'b0;
    d2 = 1'b0;
    logic_bit = 1'b0;
    neg = 1'b0;
    case (source)
      3'(SRC_PRBS): begin
        neg = prbs_cfg[PRBS_NEG_BIT];
        // Three-bit shift lowers the correlation between the ANDed copies
        d1 = prbs_cfg[PRBS_SHIFT_BIT] ? hist[2] : hist[0];
        d2 = prbs_cfg[PRBS_SHIFT_BIT] ? hist[5] : hist[1];
        if (!prbs_cfg[PRBS_MARK_BIT]) begin
          logic_bit = seq_bit;
        end else begin
          case (prbs_cfg[PRBS_RATIO_LSB +: 2])
            2'(RATIO_QUARTER): logic_bit = seq_bit & d1;
            2'(RATIO_EIGHTH):  logic_bit = seq_bit & d1 & d2;
            2'(RATIO_ZERO):    logic_bit = 1'b0;
            default:           logic_bit = seq_bit;
          endcase
        end
      end
      3'(SRC_ZSUB): begin
        neg = zs_cfg[ZS_NEG_BIT];
        if (pos < zeros_eff) begin
          logic_bit = 1'b0;
        end else if (zs_cfg[ZS_POW2_BIT] && pos == base_len) begin
          logic_bit = zs_cfg[ZS_FINAL_BIT];
        end else begin
          logic_bit = seq_bit;
        end
      end
      // The data, alternate, mixed and sequence engines sit elsewhere
      default: begin
        logic_bit = 1'b0;
      end
    endcase
  end

  // Negative polarity inverts the whole stream, which turns the positive
  // ratios into their complements
  assign next_pattern = (loading || load_cnt != 8'h0) ? neg :
                        logic_bit ^ neg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pattern_out <= 1'b0;
    end else begin
      pattern_out <= next_pattern;
    end
  end

endmodule : tppg_top
`default_nettype wire

// ---- rtl/tppg_pkg.sv ----
// Constants, register map and decode helpers of the test-pattern generator.
// Assumes a single 125 MHz clock with a synchronous active-low reset.
package tppg_pkg;

  localparam int  DATA_W      = 32;
  localparam int  ADDR_W      = 8;
  localparam int  LFSR_W      = 31;
  localparam int  CNT_W       = 24;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_SOURCE  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRBS    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ZSUB    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ZCOUNT  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h10;

  // Random-sequence register fields
  localparam int  PRBS_STAGE_LSB = 0;   // 3 bits, stage index
  localparam int  PRBS_NEG_BIT   = 3;   // sequence_polarity: negative
  localparam int  PRBS_RATIO_LSB = 4;   // 2 bits, mark ratio
  localparam int  PRBS_MARK_BIT  = 6;   // mark ratio enable
  localparam int  PRBS_SHIFT_BIT = 7;   // 0 one bit, 1 three bits
  // Zero-substitution register fields
  localparam int  ZS_STAGE_LSB   = 0;   // 3 bits, stage index 0..6
  localparam int  ZS_POW2_BIT    = 3;   // 1 selects 2^n length
  localparam int  ZS_FINAL_BIT   = 4;   // final bit value
  localparam int  ZS_NEG_BIT     = 5;   // negative_polarity

  // Reset values
  localparam logic [2:0]       RST_SOURCE = 3'h0;
  localparam logic [7:0]       RST_PRBS   = 8'h00;
  localparam logic [5:0]       RST_ZSUB   = 6'h00;
  localparam logic [CNT_W-1:0] RST_ZCOUNT = 24'h000001;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 31'h7fffffff;

  // Load time of a zero-substitution pattern
  localparam int  LOAD_TIME_NS = 256;
  localparam int  CLK_PERIOD_NS = 8;
  localparam int  LOAD_CYCLES  = (LOAD_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int  ZS_MAX_STAGE = 6;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    SRC_PRBS, SRC_ZSUB, SRC_DATA, SRC_ALT, SRC_MIXED, SRC_SEQ
  } tppg_src_e;

  typedef enum logic [1:0] {
    RATIO_HALF, RATIO_QUARTER, RATIO_EIGHTH, RATIO_ZERO
  } tppg_ratio_e;

  // Stage count for a stage index
  function automatic logic [4:0] stage_n(input logic [2:0] idx);
    case (idx)
      3'h0:    stage_n = 5'd7;
      3'h1:    stage_n = 5'd9;
      3'h2:    stage_n = 5'd10;
      3'h3:    stage_n = 5'd11;
      3'h4:    stage_n = 5'd15;
      3'h5:    stage_n = 5'd20;
      3'h6:    stage_n = 5'd23;
      default: stage_n = 5'd31;
    endcase
  endfunction : stage_n

  // Second feedback tap of the maximal-length polynomial
  function automatic logic [4:0] stage_tap(input logic [2:0] idx);
    case (idx)
      3'h0:    stage_tap = 5'd6;
      3'h1:    stage_tap = 5'd5;
      3'h2:    stage_tap = 5'd7;
      3'h3:    stage_tap = 5'd9;
      3'h4:    stage_tap = 5'd14;
      3'h5:    stage_tap = 5'd3;
      3'h6:    stage_tap = 5'd18;
      default: stage_tap = 5'd28;
    endcase
  endfunction : stage_tap

endpackage : tppg_pkg

// ---- rtl/tppg_lfsr.sv ----
// Fibonacci shift register with a selectable stage count.
// Assumes the caller steps it once per output bit and reloads on changes.
`timescale 1ns/1ns
`default_nettype none
module tppg_lfsr
  import tppg_pkg::*;
(
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Control
  input  wire logic [2:0]       stage_idx,
  input  wire logic             load,
  input  wire logic             step,
  // Sequence
  output logic                  seq_bit
);

  logic [LFSR_W-1:0] state;
  logic [LFSR_W-1:0] mask;
  logic [4:0]        n;
  logic [4:0]        t;
  logic              fb;

  assign n = stage_n(stage_idx);
  assign t = stage_tap(stage_idx);
  assign mask = LFSR_W'((64'h1 << n) - 64'h1);
  assign seq_bit = state[n - 5'd1];
  assign fb = state[n - 5'd1] ^ state[t - 5'd1];

  always_ff @(posedge aclk) begin
    if (!aresetn || load) begin
      state <= LFSR_SEED & mask;
    end else if ((state & mask) == '0) begin
      state <= LFSR_SEED & mask;
    end else if (step) begin
      state <= {state[LFSR_W-2:0], fb} & mask;
    end
  end

endmodule : tppg_lfsr
`default_nettype wire

// ---- testbench/tppg_top_props.sv ----
// Port checks of the pattern generator: bus handshakes and pattern loading.
// Assumes it is bound into tppg_top, one clock, synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module tppg_top_props
  import tppg_pkg::*;
(
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Bus handshakes
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Pattern side
  input wire logic              pattern_out,
  input wire logic              loading
);
  logic [7:0] load_cnt;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Length of the current loading pulse, zero while idle
  always_ff @(posedge aclk) begin
    if (!aresetn || !loading) load_cnt <= 8'h00;
    else load_cnt <= load_cnt + 8'h01;
  end

  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response dropped early");
  r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_latency_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pends");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pends");
  load_len_a: assert property ($fell(loading) |-> load_cnt == LOAD_CYCLES)
    else $error("loading pulse has wrong length");
  load_cap_a: assert property (load_cnt <= LOAD_CYCLES)
    else $error("loading pulse too long");
  load_hold_a: assert property (loading && $past(loading, 2) |->
    $stable(pattern_out))
    else $error("pattern moved while loading");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cover property ($fell(loading));
endmodule : tppg_top_props

bind tppg_top tppg_top_props u_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .pattern_out, .loading);
`default_nettype wire

// ---- testbench/tppg_rx_model.sv ----
// Unit under test on the pattern line: stores the first DEPTH bits it samples after a clear.
// Assumes one bit per aclk edge; the bench reads rx_mem by hierarchy.
`timescale 1ns/1ns
`default_nettype none
module tppg_rx_model #(
  parameter int DEPTH = 4608
) (
  // Clock and reset
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // Line and control
  input  wire logic   pattern_in,
  input  wire logic   rx_clear,
  output logic [12:0] rx_cnt
);
  logic rx_mem [0:DEPTH-1];

  // High level is read as a one; polarity is the sender's concern
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_clear) begin
      rx_cnt <= 13'h0000;
    end else if (rx_cnt < DEPTH) begin
      rx_mem[rx_cnt] <= pattern_in;
      rx_cnt <= rx_cnt + 13'h0001;
    end
  end
endmodule : tppg_rx_model
`default_nettype wire

// ---- testbench/tppg_top_tb.sv ----
// Self-checking bench of the pattern generator over its register bus.
// Assumes the checker is bound and the receive model watches the line.
`timescale 1ns/1ns
`default_nettype none
module tppg_top_tb
  import tppg_pkg::*;
;
  logic              aclk = 1'b0, aresetn = 1'b0, rx_clear = 1'b0;
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              pattern_out, loading;
  logic [1:0]        bresp, rresp;
  logic [12:0]       rx_cnt;
  logic [31:0]       seed = 32'hf2e9;
  logic [31:0]       pr[3] = '{32'h50, 32'h40, 32'h10};
  int                nt[8] = '{7, 9, 10, 11, 15, 20, 23, 31};
  int                tp[8] = '{6, 5, 7, 9, 14, 3, 18, 28};
  int                rt[4] = '{64, 32, 16, 0};
  int                err_total = 0, n_checks = 0;

  initial forever #4 aclk = ~aclk;

  tppg_top dut (.aclk, .aresetn, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pattern_out, .loading);
  tppg_rx_model rx (.aclk, .aresetn, .pattern_in(pattern_out), .rx_clear,
    .rx_cnt);

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic int ones(input int s, input int n);
    ones = 0;
    for (int i = s; i < s + n; i++) ones += rx.rx_mem[i];
  endfunction : ones
  function automatic int diffs(input int s, input int p);
    diffs = 0;
    for (int i = s; i < s + p; i++) diffs += rx.rx_mem[i] !== rx.rx_mem[i+p];
  endfunction : diffs
  // Bits that break the feedback law o[i+n] = o[i] ^ o[i+n-t]; long
  // registers start from all ones, so their early ones count is skewed
  function automatic int recur(input int n, input int t, input int len);
    recur = 0;
    for (int i = 16; i < 16 + len; i++)
      recur += rx.rx_mem[i+n] !== (rx.rx_mem[i] ^ rx.rx_mem[i+n-t]);
  endfunction : recur
  // Signature of a window, so two settings can be compared bit for bit
  function automatic logic [31:0] sig(input int n);
    sig = 32'h0;
    for (int i = 16; i < 16 + n; i++)
      sig = {sig[30:0], rx.rx_mem[i]} ^ (sig[31] ? 32'h04c11db7 : 32'h0);
  endfunction : sig
  function automatic int zrun(input int s, input int n, output int at);
    int r;
    zrun = 0;
    r = 0;
    at = 0;
    for (int i = s; i < s + n; i++) begin
      r = rx.rx_mem[i] ? 0 : r + 1;
      if (r > zrun) begin
        zrun = r;
        at = i - r + 1;
      end
    end
  endfunction : zrun

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  task automatic give_up();
    err_total++;
    final_report();
  endtask : give_up
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp32
  task automatic cmp2(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected response at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp2

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (i == 64) give_up();
    cmp2(bresp, er);
  endtask : axi_wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (i == 64) give_up();
    cmp2(rresp, er);
    cmp32(rdata, exp);
  endtask : rd_chk
  task automatic grab(input int n);
    @(posedge aclk);
    rx_clear <= 1'b1;
    @(posedge aclk);
    rx_clear <= 1'b0;
    repeat (n) @(posedge aclk);
  endtask : grab
  // Setting up with the source parked avoids a reload per register write
  task automatic zs_run(input logic [31:0] z, input logic [31:0] kz);
    int i;
    int c;
    axi_wr(OFS_SOURCE, 32'h0, RESP_OKAY);
    repeat (2 * LOAD_CYCLES) @(posedge aclk);
    axi_wr(OFS_ZCOUNT, kz, RESP_OKAY);
    axi_wr(OFS_ZSUB, z, RESP_OKAY);
    axi_wr(OFS_SOURCE, 32'h1, RESP_OKAY);
    // The write task already stood on the first edge of the pulse
    c = loading === 1'b1;
    for (i = 0; i < 300 && (c == 0 || loading === 1'b1); i++) begin
      @(posedge aclk);
      c += loading === 1'b1;
    end
    if (i == 300) give_up();
    cmp32(c, LOAD_CYCLES);
    grab(300);
  endtask : zs_run

  initial begin
    logic [31:0] d;
    int k, l1, at;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(OFS_SOURCE, 32'h0, RESP_OKAY);
    rd_chk(OFS_PRBS, 32'h0, RESP_OKAY);
    rd_chk(OFS_ZSUB, 32'h0, RESP_OKAY);
    rd_chk(OFS_ZCOUNT, 32'h1, RESP_OKAY);
    rd_chk(8'h40, 32'h0, RESP_SLVERR);
    axi_wr(OFS_STATUS, 32'h7, RESP_SLVERR);
    for (int j = 0; j < 4; j++) begin
      seed = lfsr_next(seed);
      axi_wr(OFS_PRBS, seed, RESP_OKAY);
      rd_chk(OFS_PRBS, seed & 32'hff, RESP_OKAY);
    end
    for (int j = 0; j < 8; j++) begin
      axi_wr(OFS_PRBS, j, RESP_OKAY);
      k = (1 << nt[j]) - 1;
      if (j < 4) begin
        grab(2 * k + 20);
        cmp32(ones(16, k), 1 << (nt[j] - 1));
        cmp32(diffs(16, k), 0);
      end else begin
        grab(1100);
        cmp32(recur(nt[j], tp[j], 1024), 0);
        cmp32(ones(16, 1024) != 0, 1);
      end
    end
    for (int j = 0; j < 8; j++) begin
      seed = lfsr_next(seed);
      axi_wr(OFS_PRBS, {seed[0], 1'b1, j[1:0], j[2], 3'h0}, RESP_OKAY);
      grab(160);
      l1 = rt[j[1:0]];
      cmp32(ones(16, 127), j[2] ? 127 - l1 : l1);
    end
    for (int j = 0; j < 3; j++) begin
      axi_wr(OFS_PRBS, pr[j], RESP_OKAY);
      grab(160);
      d = sig(127);
      axi_wr(OFS_PRBS, pr[j] | 32'h80, RESP_OKAY);
      grab(160);
      cmp32(sig(127) != d, j == 0);
    end
    seed = lfsr_next(seed);
    k = 8 + seed[4:0];
    zs_run(32'h10, k);
    d = sig(254);
    cmp32(diffs(16, 127), 0);
    l1 = zrun(16, 254, at);
    cmp32(l1 >= k && l1 <= k + 12, 1);
    zs_run(32'h00, k);
    cmp32(sig(254), d);
    zs_run(32'h18, k);
    cmp32(diffs(16, 128), 0);
    l1 = zrun(16, 256, at);
    cmp32(rx.rx_mem[at-1], 1);
    zs_run(32'h08, k);
    cmp32(diffs(16, 128), 0);
    cmp32(zrun(16, 256, at) > l1, 1);
    for (int j = 2; j < 7; j++) begin
      axi_wr(OFS_SOURCE, j, RESP_OKAY);
      rd_chk(OFS_SOURCE, j < 6 ? j : 5, RESP_OKAY);
      grab(80);
      l1 = ones(16, 64);
      cmp32(l1 == 0 || l1 == 64, 1);
    end
    final_report();
  end
endmodule : tppg_top_tb
`default_nettype wire
